// >>> rtl/operand_decode_regs.vh
/*
 * constants for the two-address operand decode: operation codes, role codes,
 * field widths and the decode latency.
 * assumes decimal digits carried as 4-bit BCD and five-digit addresses.
 */
`ifndef OPERAND_DECODE_REGS_VH
`define OPERAND_DECODE_REGS_VH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define OPD_DIGIT_W        4
`define OPD_ADDR_DIGITS    5
`define OPD_ADDR_W         20
`define OPD_ROLE_W         4
`define OPD_KIND_W         4

// ----------------------------------------------------------------------------
// operation codes (two BCD digits)
// ----------------------------------------------------------------------------
`define OP_FLOAT_ADD       8'h01
`define OP_FLOAT_SUB       8'h02
`define OP_FLOAT_MUL       8'h03
`define OP_FLOAT_SHL       8'h05
`define OP_FLOAT_XMIT      8'h06
`define OP_FLOAT_BXMIT     8'h07
`define OP_FLOAT_SHR       8'h08
`define OP_FLOAT_DIV       8'h09
`define OP_ADD_IMM         8'h11
`define OP_SUB_IMM         8'h12
`define OP_MUL_IMM         8'h13
`define OP_CMP_IMM         8'h14
`define OP_XDIG_IMM        8'h15
`define OP_XFLD_IMM        8'h16
`define OP_BXMIT_IMM       8'h17
`define OP_ADD_DIR         8'h21
`define OP_SUB_DIR         8'h22
`define OP_MUL_DIR         8'h23
`define OP_CMP_DIR         8'h24
`define OP_XDIG_DIR        8'h25
`define OP_XFLD_DIR        8'h26
`define OP_BXMIT_DIR       8'h27

// ----------------------------------------------------------------------------
// operand role codes (what a resolved position means)
// ----------------------------------------------------------------------------
`define ROLE_NONE          4'h0
`define ROLE_EXP_UNITS_DST 4'h1
`define ROLE_EXP_UNITS_SRC 4'h2
`define ROLE_HIGH_ORDER    4'h3
`define ROLE_FIELD_UNITS   4'h4
`define ROLE_FIELD_DST     4'h5
`define ROLE_FIELD_SRC     4'h6
`define ROLE_DIGIT_DST     4'h7
`define ROLE_DIGIT_SRC     4'h8
`define ROLE_BRANCH_TARGET 4'h9
`define ROLE_IMM_UNITS     4'hA

// ----------------------------------------------------------------------------
// operation kinds handed to the datapath
// ----------------------------------------------------------------------------
`define KIND_NONE          4'h0
`define KIND_ADD           4'h1
`define KIND_SUB           4'h2
`define KIND_MUL           4'h3
`define KIND_DIV           4'h4
`define KIND_SHL           4'h5
`define KIND_SHR           4'h6
`define KIND_XMIT          4'h7
`define KIND_BXMIT         4'h8
`define KIND_CMP           4'h9
`define KIND_XDIG          4'hA

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define OPD_LATENCY        2

`endif

// >>> rtl/bcd_decrement.v
/*
 * five-digit BCD decrement by one, registered.
 * assumes every digit of the input is a valid BCD digit; 00000 wraps to 99999.
 */
`timescale 1ns/10ps
`include "operand_decode_regs.vh"

module bcd_decrement #(
	parameter DIGITS = `OPD_ADDR_DIGITS
) (
	// clock and reset
	input  wire                clk_in,
	input  wire                reset_in,
	// value
	input  wire [DIGITS*4-1:0] value_in,
	output reg  [DIGITS*4-1:0] result_out
);

	// ------------------------------------------------------------------------
	// ripple borrow through the digits
	// ------------------------------------------------------------------------
	reg [DIGITS*4-1:0] next_result;
	reg                borrow;
	integer            i;

	always @* begin
		next_result = {DIGITS*4{1'b0}};
		borrow = 1'b1;
		for (i = 0; i < DIGITS; i = i + 1) begin
			if (borrow && value_in[i*4 +: 4] == 4'h0) begin
				next_result[i*4 +: 4] = 4'h9;
			end else if (borrow) begin
				next_result[i*4 +: 4] = value_in[i*4 +: 4] - 4'h1;
				borrow = 1'b0;
			end else begin
				next_result[i*4 +: 4] = value_in[i*4 +: 4];
			end
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			result_out <= {DIGITS*4{1'b0}};
		end else begin
			result_out <= next_result;
		end
	end

endmodule

// >>> rtl/operand_role_table.v
/*
 * registered table from operation code to the roles of the two address
 * fields and the kind of operation.
 * assumes the opcode arrives as two BCD digits; codes not in the table
 * come out as no roles and not valid.
 */
`timescale 1ns/10ps
`include "operand_decode_regs.vh"

module operand_role_table (
	// clock and reset
	input  wire        clk_in,
	input  wire        reset_in,
	// lookup
	input  wire [7:0]  opcode_in,
	output reg  [3:0]  first_role_out,
	output reg  [3:0]  second_role_out,
	output reg  [3:0]  kind_out,
	output reg         immediate_out,
	output reg         floating_out,
	output reg         known_out
);

	reg [3:0] next_first;
	reg [3:0] next_second;
	reg [3:0] next_kind;
	reg       next_imm;
	reg       next_float;
	reg       next_known;

	// ------------------------------------------------------------------------
	// table
	// ------------------------------------------------------------------------
	always @* begin
		next_first  = `ROLE_NONE;
		next_second = `ROLE_NONE;
		next_kind   = `KIND_NONE;
		next_imm    = 1'b0;
		next_float  = 1'b0;
		next_known  = 1'b1;
		case (opcode_in)
		`OP_FLOAT_ADD: begin
			next_first  = `ROLE_EXP_UNITS_DST;
			next_second = `ROLE_EXP_UNITS_SRC;
			next_kind   = `KIND_ADD;
			next_float  = 1'b1;
		end
		`OP_FLOAT_SUB: begin
			next_first  = `ROLE_EXP_UNITS_DST;
			next_second = `ROLE_EXP_UNITS_SRC;
			next_kind   = `KIND_SUB;
			next_float  = 1'b1;
		end
		`OP_FLOAT_MUL: begin
			next_first  = `ROLE_EXP_UNITS_DST;
			next_second = `ROLE_EXP_UNITS_SRC;
			next_kind   = `KIND_MUL;
			next_float  = 1'b1;
		end
		`OP_FLOAT_SHL: begin
			next_first  = `ROLE_HIGH_ORDER;
			next_second = `ROLE_FIELD_SRC;
			next_kind   = `KIND_SHL;
			next_float  = 1'b1;
		end
		`OP_FLOAT_XMIT: begin
			next_first  = `ROLE_EXP_UNITS_DST;
			next_second = `ROLE_EXP_UNITS_SRC;
			next_kind   = `KIND_XMIT;
			next_float  = 1'b1;
		end
		`OP_FLOAT_BXMIT: begin
			next_first  = `ROLE_BRANCH_TARGET;
			next_second = `ROLE_EXP_UNITS_SRC;
			next_kind   = `KIND_BXMIT;
			next_float  = 1'b1;
		end
		`OP_FLOAT_SHR: begin
			next_first  = `ROLE_FIELD_SRC;
			next_second = `ROLE_FIELD_DST;
			next_kind   = `KIND_SHR;
			next_float  = 1'b1;
		end
		`OP_FLOAT_DIV: begin
			next_first  = `ROLE_EXP_UNITS_DST;
			next_second = `ROLE_EXP_UNITS_SRC;
			next_kind   = `KIND_DIV;
			next_float  = 1'b1;
		end
		`OP_ADD_IMM, `OP_ADD_DIR: begin
			next_first  = `ROLE_FIELD_DST;
			next_second = `ROLE_FIELD_SRC;
			next_kind   = `KIND_ADD;
			next_imm    = (opcode_in == `OP_ADD_IMM);
		end
		`OP_SUB_IMM, `OP_SUB_DIR: begin
			next_first  = `ROLE_FIELD_DST;
			next_second = `ROLE_FIELD_SRC;
			next_kind   = `KIND_SUB;
			next_imm    = (opcode_in == `OP_SUB_IMM);
		end
		`OP_MUL_IMM, `OP_MUL_DIR: begin
			// product goes to the product area, so first is only a source
			next_first  = `ROLE_FIELD_UNITS;
			next_second = `ROLE_FIELD_SRC;
			next_kind   = `KIND_MUL;
			next_imm    = (opcode_in == `OP_MUL_IMM);
		end
		`OP_CMP_IMM, `OP_CMP_DIR: begin
			next_first  = `ROLE_FIELD_UNITS;
			next_second = `ROLE_FIELD_UNITS;
			next_kind   = `KIND_CMP;
			next_imm    = (opcode_in == `OP_CMP_IMM);
		end
		`OP_XDIG_IMM, `OP_XDIG_DIR: begin
			next_first  = `ROLE_DIGIT_DST;
			next_second = `ROLE_DIGIT_SRC;
			next_kind   = `KIND_XDIG;
			next_imm    = (opcode_in == `OP_XDIG_IMM);
		end
		`OP_XFLD_IMM, `OP_XFLD_DIR: begin
			next_first  = `ROLE_FIELD_DST;
			next_second = `ROLE_FIELD_SRC;
			next_kind   = `KIND_XMIT;
			next_imm    = (opcode_in == `OP_XFLD_IMM);
		end
		`OP_BXMIT_IMM, `OP_BXMIT_DIR: begin
			next_first  = `ROLE_BRANCH_TARGET;
			next_second = `ROLE_FIELD_SRC;
			next_kind   = `KIND_BXMIT;
			next_imm    = (opcode_in == `OP_BXMIT_IMM);
		end
		default: begin
			next_known  = 1'b0;
		end
		endcase
		if (next_imm) begin
			next_second = `ROLE_IMM_UNITS;
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			first_role_out  <= `ROLE_NONE;
			second_role_out <= `ROLE_NONE;
			kind_out        <= `KIND_NONE;
			immediate_out   <= 1'b0;
			floating_out    <= 1'b0;
			known_out       <= 1'b0;
		end else begin
			first_role_out  <= next_first;
			second_role_out <= next_second;
			kind_out        <= next_kind;
			immediate_out   <= next_imm;
			floating_out    <= next_float;
			known_out       <= next_known;
		end
	end

endmodule

// >>> rtl/two_address_operand_decode.v
/*
 * operand role decode for operation codes 01 to 27 of a decimal two-address
 * instruction set: for each code it resolves what the first and second
 * address fields designate and hands the positions to the datapath.
 * assumes the fetch path gives one instruction per decode_valid_in pulse,
 * opcode as two BCD digits and addresses as five BCD digits, on clk_in.
 */
// What this block does
// - floating add: first augend/result exp, second addend exp
// - floating subtract: first minuend/result, second subtrahend exponent
// - floating multiply: first multiplicand/product, second multiplier
// - float shift left: first high-order result, second source
// - transmit floating: first destination exp, second source exp
// - branch transmit floating: store at first minus one
// - float shift right: first source units, second result
// - floating divide: first dividend/quotient, second divisor exponent
// - add: immediate uses last digit, else second address
// - subtract: immediate uses last digit, else second address
// - multiply: immediate uses last digit, else second address
// - compare first field with immediate or addressed field
// - transmit digit: one digit to first address
// - transmit field: destination units at first address
// - branch transmit: first handled like floating form
`timescale 1ns/10ps
`include "operand_decode_regs.vh"

module two_address_operand_decode #(
	parameter ADDR_W = `OPD_ADDR_W
) (
	// clock and reset
	input  wire              clk_in,
	input  wire              reset_in,
	// from instruction fetch
	input  wire              decode_valid_in,
	input  wire [7:0]        opcode_in,
	input  wire [ADDR_W-1:0] first_addr_in,
	input  wire [ADDR_W-1:0] second_addr_in,
	// to execution datapath
	output reg               result_valid_out,
	output reg               unknown_op_out,
	output reg  [3:0]        kind_out,
	output reg               floating_out,
	output reg               immediate_out,
	output reg  [3:0]        first_role_out,
	output reg  [3:0]        second_role_out,
	output reg  [ADDR_W-1:0] dest_addr_out,
	output reg  [ADDR_W-1:0] source_addr_out,
	output reg  [3:0]        immediate_units_digit_out,
	output reg               branch_out,
	output reg  [ADDR_W-1:0] branch_target_out
);

	// ------------------------------------------------------------------------
	// stage one: capture the instruction, look up roles, form first minus one
	// ------------------------------------------------------------------------
	reg              stage_valid;
	reg [ADDR_W-1:0] stage_first;
	reg [ADDR_W-1:0] stage_second;
	wire [3:0]       tbl_first;
	wire [3:0]       tbl_second;
	wire [3:0]       tbl_kind;
	wire             tbl_imm;
	wire             tbl_float;
	wire             tbl_known;
	wire [ADDR_W-1:0] first_less_one;

	always @(posedge clk_in) begin
		if (reset_in) begin
			stage_valid  <= 1'b0;
			stage_first  <= {ADDR_W{1'b0}};
			stage_second <= {ADDR_W{1'b0}};
		end else begin
			stage_valid  <= decode_valid_in;
			stage_first  <= first_addr_in;
			stage_second <= second_addr_in;
		end
	end

	operand_role_table u_table (
		.clk_in          (clk_in),
		.reset_in        (reset_in),
		.opcode_in       (opcode_in),
		.first_role_out  (tbl_first),
		.second_role_out (tbl_second),
		.kind_out        (tbl_kind),
		.immediate_out   (tbl_imm),
		.floating_out    (tbl_float),
		.known_out       (tbl_known)
	);

	// the store point of a branch-and-transmit sits one digit below its target
	bcd_decrement #(
		.DIGITS (ADDR_W/4)
	) u_dec (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.value_in   (first_addr_in),
		.result_out (first_less_one)
	);

	// ------------------------------------------------------------------------
	// stage two: steer the addresses by role
	// ------------------------------------------------------------------------
	reg [ADDR_W-1:0] next_dest;
	reg [ADDR_W-1:0] next_source;
	reg              next_branch;
	reg [ADDR_W-1:0] next_target;

	always @* begin
		next_dest   = stage_first;
		next_source = stage_second;
		next_branch = 1'b0;
		next_target = {ADDR_W{1'b0}};
		if (tbl_first == `ROLE_BRANCH_TARGET) begin
			next_dest   = first_less_one;
			next_branch = 1'b1;
			next_target = stage_first;
		end
		if (tbl_first == `ROLE_FIELD_SRC) begin
			// shift right reads at first and writes at second
			next_dest   = stage_second;
			next_source = stage_first;
		end
		if (tbl_imm) begin
			// no storage read: operand sits in the instruction itself
			next_source = {ADDR_W{1'b0}};
		end
		if (!tbl_known) begin
			next_dest   = {ADDR_W{1'b0}};
			next_source = {ADDR_W{1'b0}};
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			result_valid_out          <= 1'b0;
			unknown_op_out            <= 1'b0;
			kind_out                  <= `KIND_NONE;
			floating_out              <= 1'b0;
			immediate_out             <= 1'b0;
			first_role_out            <= `ROLE_NONE;
			second_role_out           <= `ROLE_NONE;
			dest_addr_out             <= {ADDR_W{1'b0}};
			source_addr_out           <= {ADDR_W{1'b0}};
			immediate_units_digit_out <= 4'h0;
			branch_out                <= 1'b0;
			branch_target_out         <= {ADDR_W{1'b0}};
		end else begin
			result_valid_out          <= stage_valid;
			unknown_op_out            <= stage_valid & ~tbl_known;
			kind_out                  <= tbl_kind;
			floating_out              <= tbl_float;
			immediate_out             <= tbl_imm;
			first_role_out            <= tbl_first;
			second_role_out           <= tbl_second;
			dest_addr_out             <= next_dest;
			source_addr_out           <= next_source;
			// last digit of the second field is the immediate operand's units
			immediate_units_digit_out <= tbl_imm ? stage_second[3:0] : 4'h0;
			branch_out                <= stage_valid & next_branch;
			branch_target_out         <= next_target;
		end
	end

endmodule

// >>> tb/fetch_model.sv
/*
 fetch side model: hands one instruction per clock to the operand decode.
 assumes callers are synchronous to clk_in and ask for one transfer per edge.
*/
`timescale 1ns/10ps

module fetch_model (
	// clock
	input  wire logic        clk_in,
	// instruction to the decode
	output logic             valid_out,
	output logic [7:0]       opcode_out,
	output logic [19:0]      first_out,
	output logic [19:0]      second_out
);
	initial begin
		valid_out = 1'b0;
		opcode_out = 8'h00;
		first_out = 20'h00000;
		second_out = 20'h00000;
	end

	// released lines flip so a stale value can never pass for a new one
	task idle;
		@(posedge clk_in);
		valid_out <= 1'b0;
		opcode_out <= ~opcode_out;
		first_out <= ~first_out;
		second_out <= ~second_out;
	endtask

	task issue(input logic [7:0] op, input logic [19:0] p, input logic [19:0] q);
		@(posedge clk_in);
		valid_out <= 1'b1;
		opcode_out <= op;
		first_out <= p;
		second_out <= q;
	endtask
endmodule

// >>> tb/two_address_operand_decode_assertions.sv
/*
 port checker for the operand decode.
 assumes one clock domain, synchronous active-high reset, answer 2 cycles late.
*/
`timescale 1ns/10ps
`include "operand_decode_regs.vh"

module two_address_operand_decode_assertions #(
	parameter ADDR_W = 20
) (
	input wire logic              clk_in,
	input wire logic              reset_in,
	input wire logic              decode_valid_in,
	input wire logic [7:0]        opcode_in,
	input wire logic [ADDR_W-1:0] first_addr_in,
	input wire logic [ADDR_W-1:0] second_addr_in,
	input wire logic              result_valid_out,
	input wire logic              unknown_op_out,
	input wire logic [3:0]        kind_out,
	input wire logic              floating_out,
	input wire logic              immediate_out,
	input wire logic [3:0]        first_role_out,
	input wire logic [3:0]        second_role_out,
	input wire logic [ADDR_W-1:0] dest_addr_out,
	input wire logic [ADDR_W-1:0] source_addr_out,
	input wire logic [3:0]        immediate_units_digit_out,
	input wire logic              branch_out,
	input wire logic [ADDR_W-1:0] branch_target_out
);
	// ----
	// inputs delayed to line up with the answer
	// ----
	logic [7:0]        op_d1, op_d2;
	logic [ADDR_W-1:0] p_d1, p_d2, q_d1, q_d2;

	always @(posedge clk_in) begin
		op_d1 <= opcode_in;
		op_d2 <= op_d1;
		p_d1 <= first_addr_in;
		p_d2 <= p_d1;
		q_d1 <= second_addr_in;
		q_d2 <= q_d1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_branch_req;
		decode_valid_in && opcode_in[3:0] == 4'h7 && opcode_in[7:4] <= 4'h2;
	endsequence
	sequence s_branch_ans;
		result_valid_out && branch_out && branch_target_out == p_d2;
	endsequence

	chk_answer_delay: assert property (decode_valid_in |-> ##2 result_valid_out)
		else $error("answer missing two cycles after request");
	chk_no_stray: assert property (result_valid_out |-> $past(decode_valid_in, 2))
		else $error("answer without a request");
	chk_branch_answer: assert property (s_branch_req |-> ##2 s_branch_ans)
		else $error("branch target not the first address");
	chk_branch_units: assert property (result_valid_out && branch_out |->
		dest_addr_out[3:0] == (p_d2[3:0] == 4'h0 ? 4'h9 : p_d2[3:0] - 4'h1))
		else $error("branch store not at first address minus one");
	chk_imm_digit: assert property (result_valid_out && immediate_out |->
		immediate_units_digit_out == q_d2[3:0] && second_role_out == `ROLE_IMM_UNITS
		&& source_addr_out == '0)
		else $error("immediate digit wrong");
	chk_shift_right: assert property (result_valid_out && op_d2 == 8'h08 |->
		dest_addr_out == q_d2 && source_addr_out == p_d2)
		else $error("shift right operands wrong");
	chk_direct_src: assert property (result_valid_out && op_d2[7:4] == 4'h2
		&& !unknown_op_out |-> source_addr_out == q_d2 && !immediate_out)
		else $error("direct source not the second address");
	chk_float_dest: assert property (result_valid_out && floating_out && op_d2 != 8'h07
		&& op_d2 != 8'h08 |-> dest_addr_out == p_d2 && source_addr_out == q_d2)
		else $error("floating operands wrong");
endmodule

bind two_address_operand_decode two_address_operand_decode_assertions #(.ADDR_W(ADDR_W)) u_chk (
	.clk_in(clk_in), .reset_in(reset_in), .decode_valid_in(decode_valid_in),
	.opcode_in(opcode_in), .first_addr_in(first_addr_in), .second_addr_in(second_addr_in),
	.result_valid_out(result_valid_out), .unknown_op_out(unknown_op_out),
	.kind_out(kind_out), .floating_out(floating_out), .immediate_out(immediate_out),
	.first_role_out(first_role_out), .second_role_out(second_role_out),
	.dest_addr_out(dest_addr_out), .source_addr_out(source_addr_out),
	.immediate_units_digit_out(immediate_units_digit_out), .branch_out(branch_out),
	.branch_target_out(branch_target_out));

// >>> tb/two_address_operand_decode_tb.sv
/*
 self-checking bench for the operand decode: instructions go through the
 fetch model, every answer is compared with expectations built here.
 assumes the fixed two-cycle answer and BCD addresses.
*/
`timescale 1ns/10ps
`include "operand_decode_regs.vh"

module two_address_operand_decode_tb;
	logic        clk_in, reset_in, decode_valid_in, result_valid_out, unknown_op_out;
	logic        floating_out, immediate_out, branch_out;
	logic [7:0]  opcode_in;
	logic [3:0]  kind_out, first_role_out, second_role_out, immediate_units_digit_out;
	logic [19:0] first_addr_in, second_addr_in, dest_addr_out, source_addr_out;
	logic [19:0] branch_target_out;
	logic [71:0] pending [$];
	logic [71:0] e;
	logic [7:0]  roles_pending [$];
	logic [7:0]  r;
	wire  [71:0] seen = {kind_out, floating_out, immediate_out, unknown_op_out,
		dest_addr_out, source_addr_out, immediate_units_digit_out, branch_out, branch_target_out};
	int          fail_count, comparisons;

	fetch_model i_fetch (.clk_in(clk_in), .valid_out(decode_valid_in), .opcode_out(opcode_in),
		.first_out(first_addr_in), .second_out(second_addr_in));

	two_address_operand_decode i_dut (.clk_in(clk_in), .reset_in(reset_in),
		.decode_valid_in(decode_valid_in), .opcode_in(opcode_in),
		.first_addr_in(first_addr_in), .second_addr_in(second_addr_in),
		.result_valid_out(result_valid_out), .unknown_op_out(unknown_op_out),
		.kind_out(kind_out), .floating_out(floating_out), .immediate_out(immediate_out),
		.first_role_out(first_role_out), .second_role_out(second_role_out),
		.dest_addr_out(dest_addr_out), .source_addr_out(source_addr_out),
		.immediate_units_digit_out(immediate_units_digit_out), .branch_out(branch_out),
		.branch_target_out(branch_target_out));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ----
	// expectations and comparison
	// ----
	function automatic logic [19:0] bcd_dec(input logic [19:0] v);
		logic b;
		b = 1'b1;
		bcd_dec = v;
		for (int i = 0; i < 5; i++) begin
			if (b) begin
				bcd_dec[i*4+:4] = (v[i*4+:4] == 4'h0) ? 4'h9 : v[i*4+:4] - 4'h1;
				b = (v[i*4+:4] == 4'h0);
			end
		end
	endfunction

	function automatic logic [71:0] expect_of(input logic [7:0] op, input logic [19:0] p, q);
		logic [3:0] k;
		logic fl, im, dr, unk, br;
		fl = op[7:4] == 4'h0 && op[3:0] != 4'h0 && op[3:0] != 4'h4 && op[3:0] <= 4'h9;
		im = op[7:4] == 4'h1 && op[3:0] != 4'h0 && op[3:0] <= 4'h7;
		dr = op[7:4] == 4'h2 && op[3:0] != 4'h0 && op[3:0] <= 4'h7;
		unk = !(fl || im || dr);
		case (op[3:0])
			4'h1: k = `KIND_ADD;
			4'h2: k = `KIND_SUB;
			4'h3: k = `KIND_MUL;
			4'h4: k = `KIND_CMP;
			4'h5: k = fl ? `KIND_SHL : `KIND_XDIG;
			4'h6: k = `KIND_XMIT;
			4'h7: k = `KIND_BXMIT;
			4'h8: k = `KIND_SHR;
			4'h9: k = `KIND_DIV;
			default: k = `KIND_NONE;
		endcase
		if (unk) k = `KIND_NONE;
		br = !unk && op[3:0] == 4'h7;
		return {k, fl, im, unk, unk ? 20'h0 : br ? bcd_dec(p) : (op == 8'h08 ? q : p),
			(unk || im) ? 20'h0 : (op == 8'h08 ? p : q), im ? q[3:0] : 4'h0, br, br ? p : 20'h0};
	endfunction

	// role pair {first, second} that each code gives its two address fields
	function automatic logic [7:0] roles_of(input logic [7:0] op);
		case (op)
			8'h01, 8'h02, 8'h03, 8'h06, 8'h09:
				roles_of = {`ROLE_EXP_UNITS_DST, `ROLE_EXP_UNITS_SRC};
			8'h05: roles_of = {`ROLE_HIGH_ORDER, `ROLE_FIELD_SRC};
			8'h07: roles_of = {`ROLE_BRANCH_TARGET, `ROLE_EXP_UNITS_SRC};
			8'h08: roles_of = {`ROLE_FIELD_SRC, `ROLE_FIELD_DST};
			8'h11, 8'h21, 8'h12, 8'h22, 8'h16, 8'h26:
				roles_of = {`ROLE_FIELD_DST, `ROLE_FIELD_SRC};
			8'h13, 8'h23: roles_of = {`ROLE_FIELD_UNITS, `ROLE_FIELD_SRC};
			8'h14, 8'h24: roles_of = {`ROLE_FIELD_UNITS, `ROLE_FIELD_UNITS};
			8'h15, 8'h25: roles_of = {`ROLE_DIGIT_DST, `ROLE_DIGIT_SRC};
			8'h17, 8'h27: roles_of = {`ROLE_BRANCH_TARGET, `ROLE_FIELD_SRC};
			default: roles_of = 8'h00;
		endcase
		if (op[7:4] == 4'h1 && roles_of != 8'h00)
			roles_of[3:0] = `ROLE_IMM_UNITS;
	endfunction

	task check(input string name, input logic [71:0] got, input logic [71:0] want);
		comparisons++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, want, got);
		end
	endtask

	always @(negedge clk_in) begin
		if (result_valid_out === 1'b1 && pending.size() == 0) begin
			check("stray answer", 72'h1, 72'h0);
		end else if (result_valid_out === 1'b1) begin
			e = pending.pop_front();
			r = roles_pending.pop_front();
			check("kind and flags", seen[71:65], e[71:65]);
			check("destination", seen[64:45], e[64:45]);
			check("source", seen[44:25], e[44:25]);
			check("immediate digit", seen[24:21], e[24:21]);
			check("branch", seen[20:0], e[20:0]);
			check("first role", 72'(first_role_out), 72'(r[7:4]));
			check("second role", 72'(second_role_out), 72'(r[3:0]));
		end
	end

	// ----
	// scenarios
	// ----
	task send(input logic [7:0] op, input logic [19:0] p, input logic [19:0] q);
		pending.push_back(expect_of(op, p, q));
		roles_pending.push_back(roles_of(op));
		i_fetch.issue(op, p, q);
	endtask

	task drain;
		i_fetch.idle();
		repeat (8) if (pending.size() != 0) @(posedge clk_in);
		check("answers left", 72'(pending.size()), 72'h0);
	endtask

	task automatic t_floating;
		logic [7:0] ops [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
		for (int i = 0; i < 8; i++) send(ops[i], {16'h4001, 4'(i)}, {16'h0987, 4'(i + 1)});
		drain();
	endtask

	// immediate and direct forms alternate back to back
	task t_fixed;
		for (int i = 1; i < 8; i++) begin
			send({4'h1, 4'(i)}, {16'h0302, 4'(i)}, {16'h7650, 4'(i + 2)});
			send({4'h2, 4'(i)}, {16'h0510, 4'(i)}, {16'h8834, 4'(i)});
		end
		drain();
	endtask

	// borrow runs through several digits, and 00000 wraps
	task t_borrow;
		send(8'h07, 20'h00000, 20'h00123);
		send(8'h17, 20'h10000, 20'h00008);
		send(8'h27, 20'h00100, 20'h09090);
		drain();
	endtask

	// codes just outside each decoded range, and the gap at 04
	task automatic t_unknown;
		logic [7:0] ops [7] = '{8'h00, 8'h04, 8'h10, 8'h18, 8'h20, 8'h28, 8'h99};
		for (int i = 0; i < 7; i++) begin
			send(ops[i], 20'h12345, 20'h67890);
			i_fetch.idle();
		end
		drain();
	endtask

	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	initial begin
		reset_in = 1'b1;
		fail_count = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		t_floating();
		t_fixed();
		t_borrow();
		t_unknown();
		end_sim();
	end
endmodule
